// File: include/cim_defines.vh
// Operation
// - unmasked power-good toggle pulses the interrupt; masked toggle does not.
// - unmasked thermistor state change pulses the interrupt; masked change does not.
// - unmasked reverse-mode toggle pulses the interrupt; masked toggle does not.
// - unmasked sync input status change pulses the interrupt; masked does not.
// - unmasked tracking rising edge pulses the interrupt; masked edge does not.
// - unmasked input under-voltage event pulses the interrupt; masked does not.
// - unmasked input over-voltage event pulses the interrupt; masked does not.
// - unmasked battery over-current event pulses the interrupt; masked does not.
// - unmasked battery over-voltage event pulses the interrupt; masked does not.
// - unmasked thermal trip event pulses the interrupt; masked does not.
// - unmasked safety timer expiry rising edge pulses the interrupt; masked does not.
// - unmasked gate-drive supply fault pulses the interrupt; masked does not.
// - both mask registers reset to zero, also on register reset.
// - converter enable bit; temp compensation forces run; clears on register reset or watchdog.
// - rate bit 0 continuous, 1 one-shot; resets to one-shot.
// - sample field 00/01/10 gives 15/14/13 bits; 11 reserved; resets to 10.
// - averaging bit 0 single value, 1 running average.
// - seed select 0 uses existing result, 1 uses new conversion.
// - converter control resets to 0x60.
// - each event sets its flag; reading the flag register clears it.
`ifndef CIM_DEFINES_VH
`define CIM_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CIM_OFS_CHG_MASK     8'h29
`define CIM_OFS_FAULT_MASK   8'h2A
`define CIM_OFS_CONV_CTRL    8'h2B

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define CIM_RST_CHG_MASK     8'h00
`define CIM_RST_FAULT_MASK   8'h00
`define CIM_RST_CONV_CTRL    8'h60
`define CIM_RST_EFF_BITS     4'hD
`define CIM_WR_CHG_MASK      8'h9B
`define CIM_WR_FAULT_MASK    8'hFE
`define CIM_WR_CONV_CTRL     8'hFC
`define CIM_ZERO8            8'h00

// ----------------------------------------------------------------
// charger mask / flag bit positions
// ----------------------------------------------------------------
`define CIM_B_PG             7
`define CIM_B_TS             4
`define CIM_B_REV            3
`define CIM_B_SYNC           1
`define CIM_B_MPPT           0

// ----------------------------------------------------------------
// fault mask / flag bit positions
// ----------------------------------------------------------------
`define CIM_B_UV             7
`define CIM_B_OV             6
`define CIM_B_OCP            5
`define CIM_B_BOV            4
`define CIM_B_THERMAL_TRIP          3
`define CIM_B_TMR            2
`define CIM_B_DRV            1

// ----------------------------------------------------------------
// converter control fields
// ----------------------------------------------------------------
`define CIM_B_ADC_EN         7
`define CIM_B_ADC_RATE       6
`define CIM_F_SAMPLE_HI      5
`define CIM_F_SAMPLE_LO      4
`define CIM_B_AVG            3
`define CIM_B_SEED           2
`define CIM_SAMPLE_15B       2'b00
`define CIM_SAMPLE_14B       2'b01
`define CIM_SAMPLE_13B       2'b10
`define CIM_SAMPLE_RSVD      2'b11
`define CIM_BITS_15          4'hF
`define CIM_BITS_14          4'hE
`define CIM_BITS_13          4'hD
`define CIM_BITS_NONE        4'h0

// ----------------------------------------------------------------
// edge detector geometry
// ----------------------------------------------------------------
`define CIM_TS_W             3
`define CIM_SRC_W            14

`endif

// File: core/cim_edge_detect.v
`timescale 1ns/1ps
`include "cim_defines.vh"

module cim_edge_detect (
   input  wire                    clk_sys_i,
   input  wire                    arst_n_i,
   input  wire [`CIM_SRC_W-1:0]   level_i,
   input  wire [`CIM_SRC_W-1:0]   rise_only_i,
   output wire [`CIM_SRC_W-1:0]   edge_o
);

   reg  [`CIM_SRC_W-1:0] prev_r;
   reg                   armed_r;

   // ----------------------------------------------------------------
   // previous sample, armed after first sample to avoid reset glitch
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_r  <= {`CIM_SRC_W{1'b0}};
         armed_r <= 1'b0;
      end else begin
         prev_r  <= level_i;
         armed_r <= 1'b1;
      end
   end

   // toggle, or rising edge where selected
   assign edge_o = {`CIM_SRC_W{armed_r}} & (level_i ^ prev_r) & (level_i | ~rise_only_i);

endmodule // cim_edge_detect

// File: core/cim_irq_mask_adc_ctrl.v
`timescale 1ns/1ps
`include "cim_defines.vh"

module cim_irq_mask_adc_ctrl (
   input  wire                 clk_sys_i,
   input  wire                 arst_n_i,
   // register port, decoded from the serial engine
   input  wire [7:0]           reg_addr_i,
   input  wire [7:0]           reg_wdata_i,
   input  wire                 reg_wr_i,
   input  wire                 reg_rd_i,
   output reg  [7:0]           reg_rdata_o,
   input  wire                 reg_reset_i,
   input  wire                 watchdog_expired_i,
   // flag registers, cleared by read strobes
   input  wire                 charger_flag_rd_i,
   input  wire                 fault_flag_rd_i,
   output reg  [7:0]           charger_flags_o,
   output reg  [7:0]           fault_flags_o,
   // charger status levels
   input  wire                 input_power_good_i,
   input  wire [`CIM_TS_W-1:0] thermistor_state_i,
   input  wire                 reverse_mode_i,
   input  wire                 switching_sync_input_i,
   input  wire                 max_power_track_state_i,
   // fault condition levels
   input  wire                 input_undervolt_i,
   input  wire                 input_overvolt_i,
   input  wire                 battery_overcurrent_i,
   input  wire                 battery_overvolt_i,
   input  wire                 thermal_trip_i,
   input  wire                 safety_timer_expired_i,
   input  wire                 gate_drive_supply_fault_i,
   // converter controls
   input  wire                 temp_compensation_on_i,
   output wire                 adc_run_o,
   output wire                 adc_continuous_o,
   output wire [1:0]           adc_sample_sel_o,
   output reg  [3:0]           adc_eff_bits_o,
   output wire                 averaging_on_o,
   output wire                 average_seed_sel_o,
   output wire [7:0]           charger_event_mask_b_o,
   output wire [7:0]           fault_event_mask_o,
   output reg                  int_pulse_o
);

   // register state and next values
   reg  [7:0]            chg_mask_r;
   reg  [7:0]            chg_mask_nxt;
   reg  [7:0]            fault_mask_r;
   reg  [7:0]            fault_mask_nxt;
   reg  [7:0]            conv_ctrl_r;
   reg  [7:0]            conv_ctrl_nxt;
   reg  [7:0]            chg_ev;
   reg  [7:0]            fault_ev;
   reg  [7:0]            chg_flags_nxt;
   reg  [7:0]            fault_flags_nxt;
   reg                   int_pulse_nxt;
   reg  [7:0]            rdata_nxt;
   reg  [3:0]            eff_bits_nxt;
   // decode and event wires
   wire                  sel_chg_mask;
   wire                  sel_fault_mask;
   wire                  sel_conv_ctrl;
   wire                  sample_code_rsvd;
   wire [`CIM_SRC_W-1:0] src_level;
   wire [`CIM_SRC_W-1:0] src_rise;
   wire [`CIM_SRC_W-1:0] src_edge;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // merge write data into writable bits only
   function [7:0] wr_merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] wmask;
      begin
         wr_merge = (old_v & ~wmask) | (new_v & wmask);
      end
   endfunction

   // register selected by the current offset
   function reg_hit;
      input [7:0] addr_v;
      input [7:0] ofs_v;
      begin
         reg_hit = (addr_v == ofs_v);
      end
   endfunction

   // any event whose mask bit is clear
   function unmasked_any;
      input [7:0] ev_v;
      input [7:0] mask_v;
      begin
         unmasked_any = |(ev_v & ~mask_v);
      end
   endfunction

   // read clear of flags, set beats read clear
   function [7:0] flag_update;
      input [7:0] flags_v;
      input       clear_v;
      input [7:0] ev_v;
      begin
         flag_update = (clear_v ? `CIM_ZERO8 : flags_v) | ev_v;
      end
   endfunction

   // sample code to effective resolution, zero for the refused code
   function [3:0] eff_bits;
      input [1:0] code_v;
      begin
         case (code_v)
            `CIM_SAMPLE_15B: eff_bits = `CIM_BITS_15;
            `CIM_SAMPLE_14B: eff_bits = `CIM_BITS_14;
            `CIM_SAMPLE_13B: eff_bits = `CIM_BITS_13;
            default:         eff_bits = `CIM_BITS_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // address decode, shared by writes and reads
   // ----------------------------------------------------------------
   assign sel_chg_mask     = reg_hit(reg_addr_i, `CIM_OFS_CHG_MASK);
   assign sel_fault_mask   = reg_hit(reg_addr_i, `CIM_OFS_FAULT_MASK);
   assign sel_conv_ctrl    = reg_hit(reg_addr_i, `CIM_OFS_CONV_CTRL);
   // write of the reserved sample code
   assign sample_code_rsvd = (reg_wdata_i[`CIM_F_SAMPLE_HI:`CIM_F_SAMPLE_LO] == `CIM_SAMPLE_RSVD);

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   // order: pg, ts[2:0], rev, sync, mppt, uv, ov, ocp, bov, thermal_trip, tmr, drv
   assign src_level = {input_power_good_i,          // bit 13
                       thermistor_state_i,          // bits 12:10
                       reverse_mode_i,
                       switching_sync_input_i,
                       max_power_track_state_i,
                       input_undervolt_i,
                       input_overvolt_i,
                       battery_overcurrent_i,
                       battery_overvolt_i,
                       thermal_trip_i,
                       safety_timer_expired_i,
                       gate_drive_supply_fault_i};  // bit 0
   // status bits toggle, mppt and faults trigger on entry only
   assign src_rise  = {7'b000_0001,   // status toggles, mppt rise
                       7'b111_1111};  // all faults rise

   // one edge detector for all sources
   cim_edge_detect u_edge (
      .clk_sys_i   (clk_sys_i),
      .arst_n_i    (arst_n_i),
      .level_i     (src_level),
      .rise_only_i (src_rise),
      .edge_o      (src_edge)
   );

   // map edges onto flag bit layout
   always @* begin
      chg_ev                 = `CIM_ZERO8;
      fault_ev               = `CIM_ZERO8;
      chg_ev[`CIM_B_PG]      = src_edge[13];
      chg_ev[`CIM_B_TS]      = |src_edge[12:10];
      chg_ev[`CIM_B_REV]     = src_edge[9];
      chg_ev[`CIM_B_SYNC]    = src_edge[8];
      chg_ev[`CIM_B_MPPT]    = src_edge[7];
      fault_ev[`CIM_B_UV]    = src_edge[6];
      fault_ev[`CIM_B_OV]    = src_edge[5];
      fault_ev[`CIM_B_OCP]   = src_edge[4];
      fault_ev[`CIM_B_BOV]   = src_edge[3];
      fault_ev[`CIM_B_THERMAL_TRIP] = src_edge[2];
      fault_ev[`CIM_B_TMR]   = src_edge[1];
      fault_ev[`CIM_B_DRV]   = src_edge[0];
   end

   // ----------------------------------------------------------------
   // interrupt pulse and event flags
   // ----------------------------------------------------------------
   // mask gates only the pulse; flags set regardless
   always @* begin
      int_pulse_nxt   = unmasked_any(chg_ev, chg_mask_r) | unmasked_any(fault_ev, fault_mask_r);
      chg_flags_nxt   = flag_update(charger_flags_o, charger_flag_rd_i, chg_ev);
      fault_flags_nxt = flag_update(fault_flags_o, fault_flag_rd_i, fault_ev);
   end

   // pulse and flag flip-flops
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         int_pulse_o     <= 1'b0;
         charger_flags_o <= `CIM_ZERO8;
         fault_flags_o   <= `CIM_ZERO8;
      end else begin
         int_pulse_o     <= int_pulse_nxt;
         charger_flags_o <= chg_flags_nxt;
         fault_flags_o   <= fault_flags_nxt;
      end
   end

   // ----------------------------------------------------------------
   // mask registers
   // ----------------------------------------------------------------
   // register reset beats a write in the same cycle
   always @* begin
      chg_mask_nxt   = chg_mask_r;
      fault_mask_nxt = fault_mask_r;
      if (reg_reset_i) begin
         chg_mask_nxt   = `CIM_RST_CHG_MASK;
         fault_mask_nxt = `CIM_RST_FAULT_MASK;
      end else if (reg_wr_i && sel_chg_mask) begin
         chg_mask_nxt   = wr_merge(chg_mask_r, reg_wdata_i, `CIM_WR_CHG_MASK);
      end else if (reg_wr_i && sel_fault_mask) begin
         fault_mask_nxt = wr_merge(fault_mask_r, reg_wdata_i, `CIM_WR_FAULT_MASK);
      end
   end

   // mask flip-flops
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chg_mask_r   <= `CIM_RST_CHG_MASK;
         fault_mask_r <= `CIM_RST_FAULT_MASK;
      end else begin
         chg_mask_r   <= chg_mask_nxt;
         fault_mask_r <= fault_mask_nxt;
      end
   end

   // ----------------------------------------------------------------
   // converter control register
   // ----------------------------------------------------------------
   // reserved sample code is refused, field keeps its old value
   always @* begin
      conv_ctrl_nxt = conv_ctrl_r;
      if (reg_reset_i) begin
         conv_ctrl_nxt = `CIM_RST_CONV_CTRL;
      end else begin
         if (reg_wr_i && sel_conv_ctrl) begin
            conv_ctrl_nxt = wr_merge(conv_ctrl_r, reg_wdata_i, `CIM_WR_CONV_CTRL);
            if (sample_code_rsvd) begin
               conv_ctrl_nxt[`CIM_F_SAMPLE_HI:`CIM_F_SAMPLE_LO] =
                  conv_ctrl_r[`CIM_F_SAMPLE_HI:`CIM_F_SAMPLE_LO];
            end
         end
         if (watchdog_expired_i) begin
            conv_ctrl_nxt[`CIM_B_ADC_EN] = 1'b0;
         end
      end
      eff_bits_nxt = eff_bits(conv_ctrl_nxt[`CIM_F_SAMPLE_HI:`CIM_F_SAMPLE_LO]);
   end

   // control and resolution flip-flops
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conv_ctrl_r    <= `CIM_RST_CONV_CTRL;
         adc_eff_bits_o <= `CIM_RST_EFF_BITS;
      end else begin
         conv_ctrl_r    <= conv_ctrl_nxt;
         adc_eff_bits_o <= eff_bits_nxt;
      end
   end

   // ----------------------------------------------------------------
   // converter steering
   // ----------------------------------------------------------------
   // enable, rate and field views of the control register
   assign adc_run_o          = conv_ctrl_r[`CIM_B_ADC_EN] | temp_compensation_on_i;
   assign adc_continuous_o   = ~conv_ctrl_r[`CIM_B_ADC_RATE];
   assign adc_sample_sel_o   = conv_ctrl_r[`CIM_F_SAMPLE_HI:`CIM_F_SAMPLE_LO];
   assign averaging_on_o     = conv_ctrl_r[`CIM_B_AVG];
   assign average_seed_sel_o = conv_ctrl_r[`CIM_B_SEED];

   // mask contents for the host side
   assign charger_event_mask_b_o = chg_mask_r;
   assign fault_event_mask_o     = fault_mask_r;

   // ----------------------------------------------------------------
   // read data, registered on read strobe
   // ----------------------------------------------------------------
   // reserved bits and unmapped offsets read zero
   always @* begin
      if (sel_chg_mask) begin
         rdata_nxt = chg_mask_r & `CIM_WR_CHG_MASK;
      end else if (sel_fault_mask) begin
         rdata_nxt = fault_mask_r & `CIM_WR_FAULT_MASK;
      end else if (sel_conv_ctrl) begin
         rdata_nxt = conv_ctrl_r & `CIM_WR_CONV_CTRL;
      end else begin
         rdata_nxt = `CIM_ZERO8;
      end
   end

   // read data holds until the next read strobe
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= `CIM_ZERO8;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

endmodule // cim_irq_mask_adc_ctrl

// File: tb/cim_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// host side of the decoded register port
// ---------------------------------------------
module cim_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o = 8'h00,
   output logic      [7:0] wdata_o = 8'h00,
   output logic            wr_o = 1'b0,
   output logic            rd_o = 1'b0
);
   // write: strobe held over one rising edge, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_sys_i);
      wr_o = 1'b0;
      wdata_o = ~d;
      @(negedge clk_sys_i);
   endtask
   // read: data registered at the taking edge, sampled half a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_sys_i);
      rd_o = 1'b0;
      d = rdata_i;
      @(negedge clk_sys_i);
   endtask
endmodule // cim_host_model

// File: tb/cim_irq_mask_adc_ctrl_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------
// port checker
// ---------------------------------------------
module cim_irq_chk (
   input wire logic       clk_sys_i,
   input wire logic       arst_n_i,
   input wire logic       reg_reset_i,
   input wire logic       watchdog_expired_i,
   input wire logic       temp_compensation_on_i,
   input wire logic       fault_flag_rd_i,
   input wire logic       input_power_good_i,
   input wire logic       max_power_track_state_i,
   input wire logic       thermal_trip_i,
   input wire logic       battery_overvolt_i,
   input wire logic       adc_run_o,
   input wire logic       adc_continuous_o,
   input wire logic [1:0] adc_sample_sel_o,
   input wire logic [3:0] adc_eff_bits_o,
   input wire logic       averaging_on_o,
   input wire logic       average_seed_sel_o,
   input wire logic [7:0] charger_event_mask_b_o,
   input wire logic [7:0] fault_event_mask_o,
   input wire logic [7:0] fault_flags_o,
   input wire logic       int_pulse_o
);
   logic armed_r;
   // edge detector is live from the second edge after release
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         armed_r <= 1'b0;
      else
         armed_r <= 1'b1;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   a_mask_reset: assert property (
      reg_reset_i |=> charger_event_mask_b_o == 8'h00 && fault_event_mask_o == 8'h00)
      else $error("mask registers not cleared");
   a_ctrl_reset: assert property (
      reg_reset_i |=> !adc_continuous_o && adc_sample_sel_o == 2'b10 && !averaging_on_o && !average_seed_sel_o)
      else $error("converter control not at default");
   a_wd_clear: assert property (
      watchdog_expired_i |=> adc_run_o == temp_compensation_on_i)
      else $error("watchdog left converter enabled");
   a_run_forced: assert property (
      temp_compensation_on_i |-> adc_run_o)
      else $error("converter not forced on");
   a_eff_decode: assert property (
      adc_eff_bits_o == (adc_sample_sel_o == 2'b00 ? 4'hf : adc_sample_sel_o == 2'b01 ? 4'he :
                         adc_sample_sel_o == 2'b10 ? 4'hd : 4'h0))
      else $error("resolution decode wrong");
   a_pg_pulse: assert property (
      armed_r && $changed(input_power_good_i) && !charger_event_mask_b_o[7] |=> int_pulse_o)
      else $error("power good toggle gave no pulse");
   a_mppt_rise: assert property (
      armed_r && $rose(max_power_track_state_i) && !charger_event_mask_b_o[0] |=> int_pulse_o)
      else $error("tracking rise gave no pulse");
   a_thermal_pulse: assert property (
      armed_r && $rose(thermal_trip_i) && !fault_event_mask_o[3] |=> int_pulse_o)
      else $error("thermal trip gave no pulse");
   a_flag_sets: assert property (
      armed_r && $rose(battery_overvolt_i) |=> fault_flags_o[4])
      else $error("battery overvolt flag not set");
   a_flag_clear: assert property (
      fault_flag_rd_i && !$rose(battery_overvolt_i) |=> !fault_flags_o[4])
      else $error("flag not cleared by read");
   cover property (int_pulse_o);
   cover property (watchdog_expired_i && adc_run_o);
   cover property (reg_reset_i);
endmodule // cim_irq_chk
bind cim_irq_mask_adc_ctrl cim_irq_chk chk_u (.*);

// File: tb/cim_irq_mask_adc_ctrl_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------
// testbench
// ---------------------------------------------
module cim_irq_mask_adc_ctrl_tb;
   logic       clk_sys_i = 1'b0;
   logic       arst_n_i = 1'b0;
   logic       reg_reset_i = 1'b0, watchdog_expired_i = 1'b0, temp_compensation_on_i = 1'b0;
   logic       charger_flag_rd_i = 1'b0, fault_flag_rd_i = 1'b0;
   logic [11:0] src = 12'h000;
   logic [7:0] v;
   wire  [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, charger_flags_o, fault_flags_o;
   wire  [7:0] charger_event_mask_b_o, fault_event_mask_o;
   wire  [2:0] thermistor_state_i;
   wire  [3:0] adc_eff_bits_o;
   wire  [1:0] adc_sample_sel_o;
   wire        reg_wr_i, reg_rd_i, adc_run_o, adc_continuous_o, averaging_on_o, average_seed_sel_o, int_pulse_o;
   wire        input_power_good_i, reverse_mode_i, switching_sync_input_i, max_power_track_state_i;
   wire        input_undervolt_i, input_overvolt_i, battery_overcurrent_i, battery_overvolt_i;
   wire        thermal_trip_i, safety_timer_expired_i, gate_drive_supply_fault_i;
   int         errors = 0, n_checks = 0;
   int         pos [12] = '{7, 4, 3, 1, 0, 7, 6, 5, 4, 3, 2, 1};
   // event sources, index 0 power good up to 11 gate supply
   assign {gate_drive_supply_fault_i, safety_timer_expired_i, thermal_trip_i, battery_overvolt_i,
           battery_overcurrent_i, input_overvolt_i, input_undervolt_i, max_power_track_state_i,
           switching_sync_input_i, reverse_mode_i, thermistor_state_i, input_power_good_i}
          = {src[11:2], 2'b00, src[1:0]};
   always #25 clk_sys_i = ~clk_sys_i;
   cim_irq_mask_adc_ctrl dut_u (.*);
   cim_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
                          .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
   // compare and tally
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, v);
      chk(v, e);
   endtask
   // one-cycle strobe on a control input
   task automatic strobe(ref logic s);
      s = 1'b1;
      @(negedge clk_sys_i);
      s = 1'b0;
      @(negedge clk_sys_i);
   endtask
   // read-clear both flag registers
   task automatic clr_flags;
      charger_flag_rd_i = 1'b1;
      strobe(fault_flag_rd_i);
      charger_flag_rd_i = 1'b0;
   endtask
   // drive one source level and count interrupt pulses
   task automatic ev(input int i, input logic up, input int e);
      int np;
      np = 0;
      src[i] = up;
      repeat (3) begin
         @(negedge clk_sys_i);
         np += int'(int_pulse_o !== 1'b0);
      end
      chk(np, e);
   endtask
   task print_verdict;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (6) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      rd_chk(8'h29, 8'h00);
      rd_chk(8'h2a, 8'h00);
      rd_chk(8'h2b, 8'h60);
      chk({adc_continuous_o, adc_eff_bits_o, adc_run_o}, 16'h001a);
      host_u.wr(8'h29, 8'hff);
      host_u.wr(8'h2a, 8'hff);
      host_u.wr(8'h2b, 8'hff);
      rd_chk(8'h29, 8'h9b);
      rd_chk(8'h2a, 8'hfe);
      rd_chk(8'h2b, 8'hec);
      rd_chk(8'h2c, 8'h00);
      chk(adc_run_o, 1);
      strobe(watchdog_expired_i);
      chk(adc_run_o, 0);
      rd_chk(8'h2b, 8'h6c);
      temp_compensation_on_i = 1'b1;
      @(negedge clk_sys_i);
      chk(adc_run_o, 1);
      temp_compensation_on_i = 1'b0;
      for (int c = 0; c < 3; c++) begin
         host_u.wr(8'h2b, 8'(c << 4));
         chk({adc_continuous_o, adc_eff_bits_o}, 16'h001f - c);
      end
      host_u.wr(8'h2b, 8'h0c);
      chk({averaging_on_o, average_seed_sel_o}, 16'h0003);
      strobe(reg_reset_i);
      rd_chk(8'h29, 8'h00);
      rd_chk(8'h2a, 8'h00);
      rd_chk(8'h2b, 8'h60);
      for (int m = 0; m < 2; m++) begin
         host_u.wr(8'h29, m ? 8'hff : 8'h00);
         host_u.wr(8'h2a, m ? 8'hff : 8'h00);
         for (int i = 0; i < 12; i++) begin
            ev(i, 1'b1, 1 - m);
            chk({fault_flags_o, charger_flags_o}, 16'h0001 << (pos[i] + (i > 4 ? 8 : 0)));
            clr_flags();
            chk({fault_flags_o, charger_flags_o}, 16'h0000);
            ev(i, 1'b0, int'(m == 0 && i < 4));
            chk({fault_flags_o, charger_flags_o}, i < 4 ? 16'h0001 << pos[i] : 16'h0000);
            clr_flags();
         end
      end
      print_verdict();
   end
endmodule // cim_irq_mask_adc_ctrl_tb
